// ---- design/pwt_timer.sv ----
// periodic wakeup timer with AXI4-Lite register slave and interrupt
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwt_timer #(
  parameter logic [pwt_pkg::DIV1K_W-1:0]  DIV_1K  = pwt_pkg::DIV_1K_CYC[pwt_pkg::DIV1K_W-1:0],
  parameter logic [pwt_pkg::DIV32K_W-1:0] DIV_32K = pwt_pkg::DIV_32K_CYC[pwt_pkg::DIV32K_W-1:0]
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire pwt_pkg::pwt_axi_req_t axiReq,
  output var  pwt_pkg::pwt_axi_rsp_t axiRsp,
  output logic                       wakeIrq,
  output logic                       irq
);
  import pwt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // last count value of each period, in ticks of the chosen source
  function automatic logic [CNT_W-1:0] periodLast(input logic clkSel,
                                                  input logic [PSEL_W-1:0] sel);
    logic [CNT_W-1:0] r;
    r = 16'h0000;
    if (clkSel == CLKSEL_1K) begin
      case (sel)
        3'h1: r = 16'h0007;
        3'h2: r = 16'h001F;
        3'h3: r = 16'h003F;
        3'h4: r = 16'h007F;
        3'h5: r = 16'h00FF;
        3'h6: r = 16'h01FF;
        3'h7: r = 16'h03FF;
        default: r = 16'h0000;
      endcase
    end else begin
      case (sel)
        3'h1: r = 16'h00FF;
        3'h2: r = 16'h03FF;
        3'h3: r = 16'h07FF;
        3'h4: r = 16'h0FFF;
        3'h5: r = 16'h1FFF;
        3'h6: r = 16'h3FFF;
        3'h7: r = 16'h7FFF;
        default: r = 16'h0000;
      endcase
    end
    return r;
  endfunction

  // word decode; the low two address bits are ignored
  function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return isReg(a, OFF_CTRL) || isReg(a, OFF_INT_STAT) || isReg(a, OFF_INT_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  pwt_state_t        s;
  pwt_state_t        n;
  logic              tick1k;
  logic              tick32k;
  logic              tick;
  logic              timeout;
  logic [CNT_W-1:0]  lastCnt;
  logic              awHs;
  logic              wHs;
  logic              arHs;
  logic              doWr;
  logic [ADDR_W-1:0] wAddr;
  logic [7:0]        wByte;
  logic              wLane0;
  logic              ctrlWr;
  logic              ack;
  logic [7:0]        ctrlRd;

  assign axiRsp.awready = !s.awDone && !s.bValid;
  assign axiRsp.wready  = !s.wDone && !s.bValid;
  assign axiRsp.bvalid  = s.bValid;
  assign axiRsp.bresp   = s.bResp;
  assign axiRsp.arready = !s.rValid;
  assign axiRsp.rvalid  = s.rValid;
  assign axiRsp.rdata   = s.rData;
  assign axiRsp.rresp   = s.rResp;

  assign wakeIrq = s.flag && s.intEn;
  assign irq     = s.intStat && s.intMask;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    tick1k  = (s.div1k == DIV_1K - 15'h0001);
    tick32k = (s.div32k == DIV_32K - 10'h001);
    n.div1k  = tick1k ? '0 : s.div1k + 15'h0001;
    n.div32k = tick32k ? '0 : s.div32k + 10'h001;
    tick    = (s.clkSel == CLKSEL_1K) ? tick1k : tick32k;
    lastCnt = periodLast(s.clkSel, s.perSel);
    timeout = 1'b0;
    if (s.perSel == PSEL_OFF) begin
      n.perCnt = '0;
    end else if (tick) begin
      if (s.perCnt >= lastCnt) begin
        n.perCnt = '0;
        timeout  = 1'b1;
      end else begin
        n.perCnt = s.perCnt + 16'h0001;
      end
    end

    // bus handshakes
    if (s.bValid && axiReq.bready) begin
      n.bValid = 1'b0;
    end
    if (s.rValid && axiReq.rready) begin
      n.rValid = 1'b0;
    end
    awHs = axiReq.awvalid && axiRsp.awready;
    wHs  = axiReq.wvalid && axiRsp.wready;
    arHs = axiReq.arvalid && axiRsp.arready;
    if (awHs) begin
      n.awDone = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (wHs) begin
      n.wDone  = 1'b1;
      n.wData  = axiReq.wdata[7:0];
      n.wStrb0 = axiReq.wstrb[0];
    end
    wAddr  = s.awDone ? s.awAddr : axiReq.awaddr;
    wByte  = s.wDone ? s.wData : axiReq.wdata[7:0];
    wLane0 = s.wDone ? s.wStrb0 : axiReq.wstrb[0];
    doWr   = (s.awDone || awHs) && (s.wDone || wHs);
    ctrlWr = doWr && wLane0 && isReg(wAddr, OFF_CTRL);
    ack    = ctrlWr && wByte[BIT_ACK];
    if (doWr) begin
      n.awDone = 1'b0;
      n.wDone  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (ctrlWr) begin
      n.clkSel = wByte[BIT_CLKSEL];
      n.intEn  = wByte[BIT_INTEN];
      n.perSel = wByte[PSEL_LSB +: PSEL_W];
      // a new source or period restarts the count; the 1 kHz divider keeps running,
      // so the first period after a start may be short by up to one tick
      // early first timeout
      if (wByte[BIT_CLKSEL] != s.clkSel || wByte[PSEL_LSB +: PSEL_W] != s.perSel) begin
        n.perCnt = '0;
      end
    end
    n.flag = timeout || (s.flag && !ack);
    // sticky event status, set wins over write-one-to-clear
    n.intStat = timeout || (s.intStat &&
                !(doWr && wLane0 && isReg(wAddr, OFF_INT_STAT) && wByte[0]));
    if (doWr && wLane0 && isReg(wAddr, OFF_INT_MASK)) begin
      n.intMask = wByte[0];
    end

    ctrlRd = {s.flag, 1'b0, s.clkSel, s.intEn, 1'b0, s.perSel};
    if (arHs) begin
      n.rValid = 1'b1;
      n.rResp  = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      if (isReg(axiReq.araddr, OFF_CTRL)) begin
        n.rData = {24'h000000, ctrlRd};
      end else if (isReg(axiReq.araddr, OFF_INT_STAT)) begin
        n.rData = {31'h00000000, s.intStat};
      end else if (isReg(axiReq.araddr, OFF_INT_MASK)) begin
        n.rData = {31'h00000000, s.intMask};
      end else begin
        n.rData = 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s        <= '0;
      s.clkSel <= CTRL_RESET[BIT_CLKSEL];
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge sys_clk) disable iff (rst)
    timeout |=> s.flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set after timeout");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (rst)
    (ack && !timeout) |=> !s.flag && !wakeIrq;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear flag");

  property p_ack_reads_zero;
    @(posedge sys_clk) disable iff (rst)
    s.rValid |-> !s.rData[BIT_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one");

  property p_src_1k;
    @(posedge sys_clk) disable iff (rst)
    (tick && s.clkSel == CLKSEL_1K) |=> !tick1k [*8];
  endproperty
  a_src_1k: assert property (p_src_1k) else $error("1 kHz source ticks too often");

  property p_req;
    @(posedge sys_clk) disable iff (rst)
    $rose(wakeIrq) |-> $past(timeout) || $past(ctrlWr && wByte[BIT_INTEN]);
  endproperty
  a_req: assert property (p_req) else $error("request rose without timeout or enable");

  property p_enable_gate;
    @(posedge sys_clk) disable iff (rst)
    (ctrlWr && !wByte[BIT_INTEN]) |=> !wakeIrq;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("request despite disable");

  property p_off;
    @(posedge sys_clk) disable iff (rst)
    (s.perSel == PSEL_OFF) |-> !timeout ##1 (s.perCnt == '0);
  endproperty
  a_off: assert property (p_off) else $error("timer ran with period code zero");

  property p_period;
    @(posedge sys_clk) disable iff (rst)
    timeout |-> tick && s.perCnt == periodLast(s.clkSel, s.perSel);
  endproperty
  a_period: assert property (p_period) else $error("timeout at wrong count");

  property p_period_run;
    @(posedge sys_clk) disable iff (rst)
    (tick && s.perSel != PSEL_OFF && s.perCnt < lastCnt && !ctrlWr)
      |=> s.perCnt == $past(s.perCnt) + 16'h0001;
  endproperty
  a_period_run: assert property (p_period_run) else $error("period count stalled");

  property p_div_step;
    @(posedge sys_clk) disable iff (rst)
    !tick1k |=> s.div1k == $past(s.div1k) + 15'h0001;
  endproperty
  a_div_step: assert property (p_div_step) else $error("1 kHz divider skipped");

  property p_mask_write;
    @(posedge sys_clk) disable iff (rst)
    (doWr && wLane0 && isReg(wAddr, OFF_INT_MASK)) |=> s.intMask == $past(wByte[0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_b_once;
    @(posedge sys_clk) disable iff (rst)
    (s.bValid && axiReq.bready) |=> !s.bValid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");

  property p_r_once;
    @(posedge sys_clk) disable iff (rst)
    (s.rValid && axiReq.rready) |=> !s.rValid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read response repeated");

  property p_write_resp;
    @(posedge sys_clk) disable iff (rst)
    (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready) |=> s.bValid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("no write response");

  property p_read_resp;
    @(posedge sys_clk) disable iff (rst)
    (axiReq.arvalid && axiRsp.arready) |=> s.rValid;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("no read response");

  property p_rdata_high;
    @(posedge sys_clk) disable iff (rst)
    s.rValid |-> s.rData[31:8] == 24'h000000;
  endproperty
  a_rdata_high: assert property (p_rdata_high) else $error("upper read bits not zero");

  property p_flag_zero;
    @(posedge sys_clk) disable iff (rst)
    (!s.flag && !timeout) |=> !s.flag;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag set without timeout");

  property p_flag_hold;
    @(posedge sys_clk) disable iff (rst)
    (s.flag && !ack) |=> s.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without acknowledge");

  property p_irq_rise;
    @(posedge sys_clk) disable iff (rst)
    (timeout && s.intEn && !ctrlWr) |=> wakeIrq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("no request after timeout");

  property p_ctrl_fields;
    @(posedge sys_clk) disable iff (rst)
    ctrlWr |=> s.clkSel == $past(wByte[BIT_CLKSEL]) &&
               s.intEn == $past(wByte[BIT_INTEN]);
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control bits not kept");

  property p_persel_write;
    @(posedge sys_clk) disable iff (rst)
    ctrlWr |=> s.perSel == $past(wByte[PSEL_LSB +: PSEL_W]);
  endproperty
  a_persel_write: assert property (p_persel_write) else $error("period code not kept");

  property p_src_32k;
    @(posedge sys_clk) disable iff (rst)
    (s.clkSel != CLKSEL_1K && !tick32k && !ctrlWr) |=> $stable(s.perCnt);
  endproperty
  a_src_32k: assert property (p_src_32k) else $error("count moved off the 32 kHz tick");

  property p_div_range;
    @(posedge sys_clk) disable iff (rst)
    s.div1k < DIV_1K && s.div32k < DIV_32K;
  endproperty
  a_div_range: assert property (p_div_range) else $error("divider out of range");

  property p_stat_set;
    @(posedge sys_clk) disable iff (rst)
    timeout |=> s.intStat;
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status not set after timeout");

  property p_strb_ignore;
    @(posedge sys_clk) disable iff (rst)
    (doWr && !wLane0) |=> $stable(s.clkSel) && $stable(s.intEn) &&
                          $stable(s.perSel) && $stable(s.intMask);
  endproperty
  a_strb_ignore: assert property (p_strb_ignore) else $error("write without strobe landed");

  property p_bad_addr;
    @(posedge sys_clk) disable iff (rst)
    (doWr && !isMapped(wAddr)) |=> s.bResp == RESP_SLVERR;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped write not refused");

endmodule
`default_nettype wire

// ---- design/pwt_pkg.sv ----
// package: constants, types and register map of the periodic wakeup timer
// Contract
// - timeout_flag, bit 7, sets when the selected period ends; holds until acknowledged
// - writing 1 to timeout_acknowledge, bit 6, clears the flag; reads 0
// - timer_clock_select, bit 5, chooses the 1 kHz or 32 kHz counting source
// - timer_interrupt_enable, bit 4, gates the wakeIrq request, not irq; 1 enables
// - period_select bits 2:0 choose the period; 000 stops the timer
// - 1 kHz codes 001..111 give 8,32,64,128,256,512 ms and 1.024 s
// - 32 kHz codes 001..111 give 256 up to 32768 source cycles
// - 1 kHz periods count whole 1 ms oscillator ticks
// - first 1 kHz timeout after start may come up to one tick early
package pwt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned SYS_CLK_HZ  = 20_000_000;
  localparam int unsigned OSC_1K_HZ   = 1_000;
  localparam int unsigned ICS_32K_HZ  = 32_000;
  localparam int unsigned DIV_1K_CYC  = SYS_CLK_HZ / OSC_1K_HZ;
  localparam int unsigned DIV_32K_CYC = SYS_CLK_HZ / ICS_32K_HZ;
  localparam int unsigned DIV1K_W     = 15;
  localparam int unsigned DIV32K_W    = 10;
  localparam int unsigned CNT_W       = 16;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 4'h8;

  localparam int unsigned BIT_FLAG   = 7;
  localparam int unsigned BIT_ACK    = 6;
  localparam int unsigned BIT_CLKSEL = 5;
  localparam int unsigned BIT_INTEN  = 4;
  localparam int unsigned PSEL_LSB   = 0;
  localparam int unsigned PSEL_W     = 3;
  localparam logic [PSEL_W-1:0] PSEL_OFF = 3'h0;
  localparam logic CLKSEL_1K = 1'b0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pwt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pwt_axi_rsp_t;

  typedef struct packed {
    logic                flag;
    logic                clkSel;
    logic                intEn;
    logic [PSEL_W-1:0]   perSel;
    logic [CNT_W-1:0]    perCnt;
    logic [DIV1K_W-1:0]  div1k;
    logic [DIV32K_W-1:0] div32k;
    logic                intStat;
    logic                intMask;
    logic                awDone;
    logic                wDone;
    logic [ADDR_W-1:0]   awAddr;
    logic [7:0]          wData;
    logic                wStrb0;
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
  } pwt_state_t;

endpackage

// ---- verification/pwt_timer_bench.sv ----
// self-checking bench for the periodic wakeup timer
`timescale 1ns/10ps
`default_nettype none
module pwt_timer_bench;
  import pwt_pkg::*;
  localparam logic [DIV1K_W-1:0]  D1 = 15'h000A;
  localparam logic [DIV32K_W-1:0] D32 = 10'h003;
  logic         sys_clk = 1'b0;
  logic         rst     = 1'b1;
  pwt_axi_req_t req     = '0;
  pwt_axi_rsp_t rsp;
  logic         wakeIrq;
  logic         irq;
  int           errCount = 0;
  int           checks   = 0;
  int           cyc      = 0;
  integer       seed     = 32'h2e470384;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           t0, t1, t2, n;
  logic [7:0]   v;
  pwt_timer #(.DIV_1K(D1), .DIV_32K(D32)) dut (
    .sys_clk(sys_clk), .rst(rst), .axiReq(req), .axiRsp(rsp), .wakeIrq(wakeIrq), .irq(irq));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // handshakes are judged at the falling edge, acted on after the next rising one
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    @(posedge sys_clk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= s; req.bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw = req.awvalid && rsp.awready; w = req.wvalid && rsp.wready; b = rsp.bvalid;
      if (b) rs = rsp.bresp;
      @(posedge sys_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
    end while (!b);
  endtask
  task automatic rdr(input logic [3:0] a);
    logic b;
    @(posedge sys_clk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      b = rsp.rvalid;
      if (b) begin rd = rsp.rdata; rs = rsp.rresp; end
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (b) req.rready <= 1'b0;
    end while (!b);
  endtask
  task automatic wait_rise(output int t);
    n = 0;
    while (wakeIrq !== 1'b1 && n < 12000) begin @(negedge sys_clk); n++; end
    t = cyc;
  endtask
  function automatic int ticks(input logic sel, input int c);
    if (sel == CLKSEL_1K) return (c == 1) ? 8 : (1 << (c + 3));
    return (c == 1) ? 256 : (1 << (c + 8));
  endfunction
  // one period code: first period may be short by a tick, the next is exact
  task automatic run(input logic sel, input int c);
    int per, dv;
    dv  = (sel == CLKSEL_1K) ? int'(D1) : int'(D32);
    per = ticks(sel, c) * dv;
    wr(OFF_CTRL, 32'h50 | (32'(sel) << 5) | 32'(c), 4'hF);
    t0 = cyc;
    wait_rise(t1);
    check("first_long", 32'(t1 - t0 <= per + 2), 32'h1); // not late
    check("first_short", 32'(t1 - t0 >= per - dv), 32'h1); // one tick early at most
    wr(OFF_CTRL, 32'h50 | (32'(sel) << 5) | 32'(c), 4'hF);
    check("irq_ack", 32'(wakeIrq), 32'h0); // drops on ack
    wait_rise(t2);
    check("period", 32'(t2 - t1), 32'(per)); // exact period
    $display("period test sel %0d code %0d done", sel, c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge sys_clk);
    errCount++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rdr(OFF_CTRL);
    check("ctrl_reset", rd, 32'(CTRL_RESET)); // flag reads 0
    rdr(4'hC);
    check("unmapped", 32'(rs), 32'(RESP_SLVERR));
    check("unmapped_rd", rd, 32'h0);
    wr(4'hC, 32'h1, 4'hF);
    check("unmapped_wr", 32'(rs), 32'(RESP_SLVERR));
    // period code 000 keeps the timer off
    wr(OFF_CTRL, 32'h10, 4'hF);
    check("wr_okay", 32'(rs), 32'(RESP_OKAY));
    repeat (300) @(posedge sys_clk);
    rdr(OFF_INT_STAT);
    check("off_stat", rd, 32'h0); // disabled
    check("rd_okay", 32'(rs), 32'(RESP_OKAY));
    $display("reset and off test done");
    for (int c = 1; c < 8; c++) run(CLKSEL_1K, c); // every 1 kHz code
    for (int c = 1; c < 4; c++) run(1'b1, c); // short 32 kHz codes only
    wr(OFF_CTRL, 32'h50, 4'hF);
    rdr(OFF_INT_STAT);
    check("stat_sticky", rd, 32'h1);
    check("irq_masked", 32'(irq), 32'h0);
    wr(OFF_INT_MASK, 32'h1, 4'hF);
    check("irq_unmasked", 32'(irq), 32'h1);
    wr(OFF_INT_STAT, 32'h1, 4'hF);
    check("irq_cleared", 32'(irq), 32'h0);
    $display("interrupt test done");
    // flag without enable, write of 0 to acknowledge, then real acknowledge
    wr(OFF_CTRL, 32'h01, 4'hF);
    repeat (200) @(posedge sys_clk);
    rdr(OFF_CTRL);
    check("flag_set", rd, 32'h81); // timeout shown, ack reads 0
    check("irq_gated", 32'(wakeIrq), 32'h0); // enable off
    wr(OFF_CTRL, 32'h11, 4'hF);
    check("irq_on", 32'(wakeIrq), 32'h1); // flag and enable
    wr(OFF_CTRL, 32'h01, 4'hF);
    check("irq_en_off", 32'(wakeIrq), 32'h0); // enable cleared
    rdr(OFF_CTRL);
    check("ack0", rd, 32'h81); // zero does nothing
    wr(OFF_CTRL, 32'h40, 4'hF);
    rdr(OFF_CTRL);
    check("ack1", rd, 32'h0); // one clears
    wr(OFF_CTRL, 32'h07, 4'h0);
    rdr(OFF_CTRL);
    check("strb0", rd, 32'h0);
    $display("flag test done");
    // random settings read back; flag bit left out as a timeout may land
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr(OFF_CTRL, 32'(v), 4'hF);
      rdr(OFF_CTRL);
      check("ctrl_rw", rd & 32'h7F, 32'(v & 8'h37)); // fields kept
    end
    wr(OFF_CTRL, 32'h40, 4'hF);
    $display("random test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
